// file: pwmcs_pkg.sv
// constants for the control and scaled clock block
package pwmcs_pkg;
	localparam logic [7:0] ADDR_CONTROL = 8'h05;
	localparam logic [7:0] ADDR_FACTORY_TEST = 8'h06;
	localparam logic [7:0] ADDR_FACTORY_PRESCALE = 8'h07;
	localparam logic [7:0] ADDR_SCALE_A = 8'h08;
	localparam logic [7:0] ADDR_SCALE_B = 8'h09;
	localparam logic [7:0] ADDR_SCALE_COUNT_A = 8'h0A;
	localparam logic [7:0] ADDR_SCALE_COUNT_B = 8'h0B;
	localparam logic [7:0] ADDR_PRESCALE = 8'h03;
	localparam logic [7:0] ADDR_CLOCK_SELECT = 8'h02;
	localparam logic [7:0] ADDR_COUNTER_WRITE = 8'h0C;
	localparam int BIT_JOIN_HI = 5;
	localparam int BIT_JOIN_LO = 4;
	localparam int BIT_STOP_WAIT = 3;
	localparam int BIT_STOP_FREEZE = 2;
	localparam logic [7:0] CONTROL_RESET = 8'h00;
	localparam logic [7:0] CONTROL_MASK = 8'h3C;
	localparam logic [7:0] SCALE_RESET = 8'h00;
	localparam logic [7:0] PRESCALE_MASK = 8'h77;
	localparam logic [7:0] ZERO_BYTE = 8'h00;
	localparam int PRESCALE_STAGES = 7;
	localparam int FULL_SCALE = 256;
endpackage

// file: pwmcs_prescaler.sv
// power-of-two prescaler giving clock a and clock b enables
`timescale 1ns/10ps
module pwmcs_prescaler #(
	parameter int STAGES = pwmcs_pkg::PRESCALE_STAGES
) (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_run,
	input wire logic [2:0] i_sel_a,
	input wire logic [2:0] i_sel_b,
	output logic o_tick_a,
	output logic o_tick_b
);
	initial begin
		if (STAGES != 7) $error("prescaler needs seven stages");
	end
	logic [STAGES-1:0] count;
	logic [STAGES:0] tick;
	always_ff @(posedge i_clk) begin
		if (i_reset) count <= '0;
		else if (i_run) count <= count + 1'b1;
	end
	// stage k ticks once every 2**k enabled cycles
	assign tick[0] = i_run;
	genvar k;
	generate
		for (k = 1; k <= STAGES; k++) begin : g_tick
			assign tick[k] = i_run && (count[k-1:0] == {k{1'b1}});
		end
	endgenerate
	assign o_tick_a = tick[i_sel_a];
	assign o_tick_b = tick[i_sel_b];
endmodule

// file: pwmcs_scaler.sv
// reloadable scale counter making one scaled clock
`timescale 1ns/10ps
module pwmcs_scaler (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_tick,
	input wire logic i_load,
	input wire logic [7:0] i_value,
	output logic o_tick,
	output logic o_level
);
	logic [7:0] count;
	// zero reloads as 256 through the wrap of the 8-bit down count
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			count <= pwmcs_pkg::SCALE_RESET;
			o_level <= 1'b0;
		end else if (i_load) begin
			count <= i_value;
		end else if (i_tick) begin
			if (count == 8'h01) begin
				count <= i_value;
				o_level <= ~o_level;
			end else begin
				count <= count - 8'h01;
			end
		end
	end
	assign o_tick = i_tick && (count == 8'h01) && !i_load;
endmodule

// file: pwmcs_top.sv
// control register, low-power gating and scaled clocks of the pwm
`timescale 1ns/10ps
module pwmcs_top (
	input wire logic i_clk,
	input wire logic i_reset,
	input wire logic i_ce,
	input wire logic i_wait_mode,
	input wire logic i_freeze_mode,
	input wire logic [7:0] i_addr,
	input wire logic [7:0] i_wdata,
	input wire logic i_wr,
	input wire logic i_rd,
	output logic [7:0] o_rdata,
	output logic [3:0] o_chan_tick,
	output logic o_scaled_clock_a,
	output logic o_scaled_clock_b,
	output logic o_join_pair_hi,
	output logic o_join_pair_lo,
	output logic [1:0] o_pulse_output_sel,
	output logic [3:0] o_counter_reset,
	output logic o_prescale_running
);
	logic [7:0] pwm_control;
	logic [7:0] scale_a_value;
	logic [7:0] scale_b_value;
	logic [7:0] prescale_select;
	logic [3:0] clock_select;
	logic prescale_run;
	logic tick_a, tick_b, stick_a, stick_b, level_a, level_b;
	logic wr_scale_a, wr_scale_b;
	logic [7:0] load_a, load_b;
	logic [7:0] next_rdata;
	logic [3:0] next_chan_tick;
	logic [3:0] next_counter_reset;

	// gating is combinational so the clock stops in the same cycle as the mode
	assign prescale_run = i_ce
		&& !(pwm_control[pwmcs_pkg::BIT_STOP_WAIT] && i_wait_mode)
		&& !(pwm_control[pwmcs_pkg::BIT_STOP_FREEZE] && i_freeze_mode);
	assign wr_scale_a = i_ce && i_wr && (i_addr == pwmcs_pkg::ADDR_SCALE_A);
	assign wr_scale_b = i_ce && i_wr && (i_addr == pwmcs_pkg::ADDR_SCALE_B);
	// terminal reloads must use the stored scale, not whatever sits on the bus
	assign load_a = wr_scale_a ? i_wdata : scale_a_value;
	assign load_b = wr_scale_b ? i_wdata : scale_b_value;

	// register writes ignore freeze so software can always reach them
	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			pwm_control <= pwmcs_pkg::CONTROL_RESET;
		end else if (i_ce && i_wr && i_addr == pwmcs_pkg::ADDR_CONTROL) begin
			pwm_control <= i_wdata & pwmcs_pkg::CONTROL_MASK;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			scale_a_value <= pwmcs_pkg::SCALE_RESET;
			scale_b_value <= pwmcs_pkg::SCALE_RESET;
		end else begin
			if (wr_scale_a) scale_a_value <= i_wdata;
			if (wr_scale_b) scale_b_value <= i_wdata;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			prescale_select <= pwmcs_pkg::ZERO_BYTE;
			clock_select <= 4'h0;
		end else if (i_ce && i_wr) begin
			if (i_addr == pwmcs_pkg::ADDR_PRESCALE)
				prescale_select <= i_wdata & pwmcs_pkg::PRESCALE_MASK;
			if (i_addr == pwmcs_pkg::ADDR_CLOCK_SELECT)
				clock_select <= i_wdata[3:0];
		end
	end

	pwmcs_prescaler u_prescaler (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_run(prescale_run),
		.i_sel_a(prescale_select[2:0]),
		.i_sel_b(prescale_select[6:4]),
		.o_tick_a(tick_a),
		.o_tick_b(tick_b)
	);

	pwmcs_scaler u_scaler_a (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_tick(tick_a),
		.i_load(wr_scale_a),
		.i_value(load_a),
		.o_tick(stick_a),
		.o_level(level_a)
	);

	pwmcs_scaler u_scaler_b (
		.i_clk(i_clk),
		.i_reset(i_reset),
		.i_tick(tick_b),
		.i_load(wr_scale_b),
		.i_value(load_b),
		.o_tick(stick_b),
		.o_level(level_b)
	);

	// channel counters advance on clock a/b ticks, or on scaled edges when their clock select bit is set: one tick per scaled half period
	always_comb begin
		next_chan_tick[0] = clock_select[0] ? stick_a : tick_a;
		next_chan_tick[1] = clock_select[1] ? stick_a : tick_a;
		next_chan_tick[2] = clock_select[2] ? stick_b : tick_b;
		next_chan_tick[3] = clock_select[3] ? stick_b : tick_b;
		// joined pair runs from the higher (odd) channel's clock select
		if (pwm_control[pwmcs_pkg::BIT_JOIN_LO])
			next_chan_tick[0] = next_chan_tick[1];
		if (pwm_control[pwmcs_pkg::BIT_JOIN_HI])
			next_chan_tick[2] = next_chan_tick[3];
	end

	always_comb begin
		next_counter_reset = 4'h0;
		if (i_ce && i_wr && i_addr[7:2] == pwmcs_pkg::ADDR_COUNTER_WRITE[7:2])
			next_counter_reset[i_addr[1:0]] = 1'b1;
		// a write to either byte of a joined counter clears both halves
		if (pwm_control[pwmcs_pkg::BIT_JOIN_LO] && |next_counter_reset[1:0])
			next_counter_reset[1:0] = 2'b11;
		if (pwm_control[pwmcs_pkg::BIT_JOIN_HI] && |next_counter_reset[3:2])
			next_counter_reset[3:2] = 2'b11;
	end

	always_comb begin
		next_rdata = pwmcs_pkg::ZERO_BYTE;
		unique case (i_addr)
			pwmcs_pkg::ADDR_CONTROL: next_rdata = pwm_control;
			pwmcs_pkg::ADDR_SCALE_A: next_rdata = scale_a_value;
			pwmcs_pkg::ADDR_SCALE_B: next_rdata = scale_b_value;
			pwmcs_pkg::ADDR_PRESCALE: next_rdata = prescale_select;
			pwmcs_pkg::ADDR_CLOCK_SELECT: next_rdata = {4'h0, clock_select};
			// factory and scale count locations read zero and store nothing
			pwmcs_pkg::ADDR_FACTORY_TEST,
			pwmcs_pkg::ADDR_FACTORY_PRESCALE,
			pwmcs_pkg::ADDR_SCALE_COUNT_A,
			pwmcs_pkg::ADDR_SCALE_COUNT_B: next_rdata = pwmcs_pkg::ZERO_BYTE;
			default: next_rdata = pwmcs_pkg::ZERO_BYTE;
		endcase
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_rdata <= pwmcs_pkg::ZERO_BYTE;
		end else if (i_ce) begin
			o_rdata <= i_rd ? next_rdata : pwmcs_pkg::ZERO_BYTE;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_chan_tick <= 4'h0;
			o_counter_reset <= 4'h0;
			o_scaled_clock_a <= 1'b0;
			o_scaled_clock_b <= 1'b0;
			o_prescale_running <= 1'b0;
		end else if (i_ce) begin
			o_chan_tick <= next_chan_tick;
			o_counter_reset <= next_counter_reset;
			o_scaled_clock_a <= level_a;
			o_scaled_clock_b <= level_b;
			o_prescale_running <= prescale_run;
		end
	end

	always_ff @(posedge i_clk) begin
		if (i_reset) begin
			o_join_pair_hi <= 1'b0;
			o_join_pair_lo <= 1'b0;
			o_pulse_output_sel <= 2'b00;
		end else if (i_ce) begin
			o_join_pair_hi <= pwm_control[pwmcs_pkg::BIT_JOIN_HI];
			o_join_pair_lo <= pwm_control[pwmcs_pkg::BIT_JOIN_LO];
			// bit set: joined pair drives only the low channel pin
			o_pulse_output_sel <= {pwm_control[pwmcs_pkg::BIT_JOIN_HI],
				pwm_control[pwmcs_pkg::BIT_JOIN_LO]};
		end
	end

	a_reset_control: assert property (@(posedge i_clk) i_reset |=> pwm_control == 8'h00)
		else $error("control not zero after reset");
	a_wait_gate: assert property (@(posedge i_clk) disable iff (i_reset)
		(pwm_control[3] && i_wait_mode) |-> !prescale_run)
		else $error("prescaler runs in wait");
	a_freeze_gate: assert property (@(posedge i_clk) disable iff (i_reset)
		(pwm_control[2] && i_freeze_mode) |-> !tick_a && !tick_b)
		else $error("prescaler runs in freeze");
	a_freeze_resume: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && !i_freeze_mode && !(pwm_control[3] && i_wait_mode)) |-> prescale_run)
		else $error("prescaler not resumed");
	a_test_reads_zero: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && i_rd && (i_addr == 8'h06 || i_addr == 8'h0A)) |=> o_rdata == 8'h00)
		else $error("factory location not zero");
	a_scale_write: assert property (@(posedge i_clk) disable iff (i_reset)
		wr_scale_a |=> scale_a_value == $past(i_wdata) && u_scaler_a.count == $past(i_wdata))
		else $error("scale a not reloaded");
	a_scaled_toggle: assert property (@(posedge i_clk) disable iff (i_reset)
		(tick_b && u_scaler_b.count == 8'h01 && !wr_scale_b) |=> level_b != $past(level_b))
		else $error("scaled b did not toggle");
	a_join_tick: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && pwm_control[4]) |=> o_chan_tick[0] == o_chan_tick[1])
		else $error("joined pair ticks differ");
	a_join_reset: assert property (@(posedge i_clk) disable iff (i_reset)
		(i_ce && pwm_control[5] && i_wr && i_addr == 8'h0E) |=> o_counter_reset[3:2] == 2'b11)
		else $error("joined counter not fully reset");
endmodule

// file: testbench.sv
// self-checking bench for the control register, gating and scaled clocks
`timescale 1ns/10ps
module testbench;
	logic i_clk = 1'b0;
	logic i_reset = 1'b1;
	logic i_ce = 1'b1;
	logic i_wait_mode = 1'b0;
	logic i_freeze_mode = 1'b0;
	logic [7:0] i_addr = 8'h00;
	logic [7:0] i_wdata = 8'h00;
	logic i_wr = 1'b0;
	logic i_rd = 1'b0;
	logic [7:0] o_rdata;
	logic [3:0] o_chan_tick;
	logic o_scaled_clock_a;
	logic o_scaled_clock_b;
	logic o_join_pair_hi;
	logic o_join_pair_lo;
	logic [1:0] o_pulse_output_sel;
	logic [3:0] o_counter_reset;
	logic o_prescale_running;
	int mismatches = 0;
	int checked = 0;
	int n;
	logic held;
	pwmcs_top u_pwmcs_top (.i_clk(i_clk), .i_reset(i_reset), .i_ce(i_ce),
		.i_wait_mode(i_wait_mode), .i_freeze_mode(i_freeze_mode), .i_addr(i_addr),
		.i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata),
		.o_chan_tick(o_chan_tick), .o_scaled_clock_a(o_scaled_clock_a),
		.o_scaled_clock_b(o_scaled_clock_b), .o_join_pair_hi(o_join_pair_hi),
		.o_join_pair_lo(o_join_pair_lo), .o_pulse_output_sel(o_pulse_output_sel),
		.o_counter_reset(o_counter_reset), .o_prescale_running(o_prescale_running));
	always #12.5 i_clk = ~i_clk;
	task automatic end_of_test();
		$display("checked %0d mismatches %0d", checked, mismatches);
		if (mismatches == 0 && checked > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask
	task automatic cmp(input string name, input logic [7:0] exp, input logic [7:0] got);
		checked++;
		if (got !== exp) begin
			mismatches++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask
	task automatic cmp_n(input string name, input int exp, input int got);
		checked++;
		if (got != exp) begin
			mismatches++;
			$display("Error %s expected %0d seen %0d", name, exp, got);
		end
	endtask
	// one-cycle strobes, entered just after a rising edge
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		i_wr <= 1'b1;
		i_addr <= a;
		i_wdata <= d;
		@(posedge i_clk);
		i_wr <= 1'b0;
		#1;
	endtask
	task automatic rd(input string name, input logic [7:0] a, input logic [7:0] exp);
		i_rd <= 1'b1;
		i_addr <= a;
		@(posedge i_clk);
		i_rd <= 1'b0;
		#1;
		cmp(name, exp, o_rdata);
	endtask
	function automatic logic lvl(input bit b);
		return b ? o_scaled_clock_b : o_scaled_clock_a;
	endfunction
	// cycles until the scaled level next changes, bounded
	task automatic gap(input bit b, output int cnt);
		logic l;
		cnt = 0;
		l = lvl(b);
		while (lvl(b) === l && cnt < 1000) begin
			@(posedge i_clk);
			#1;
			cnt++;
		end
	endtask
	task automatic period(input string name, input bit b, input int exp);
		int k;
		gap(b, k);
		gap(b, k);
		cmp_n(name, exp, k);
	endtask
	task automatic ticks(input int ch, output int cnt);
		cnt = 0;
		repeat (2) @(posedge i_clk);
		repeat (12) begin
			@(posedge i_clk);
			#1;
			if (o_chan_tick[ch] === 1'b1) cnt++;
		end
	endtask
	task automatic run_chk(input logic exp);
		repeat (3) @(posedge i_clk);
		#1;
		cmp("prescale running", {7'h00, exp}, {7'h00, o_prescale_running});
	endtask
	initial begin
		repeat (12) @(posedge i_clk);
		i_reset <= 1'b0;
		@(posedge i_clk);
		rd("control reset", pwmcs_pkg::ADDR_CONTROL, 8'h00);
		cmp("join outputs", 8'h00, {4'h0, o_join_pair_hi, o_join_pair_lo, o_pulse_output_sel});
		wr(pwmcs_pkg::ADDR_CONTROL, 8'hFF);
		rd("control mask", pwmcs_pkg::ADDR_CONTROL, 8'h3C);
		cmp("both joined", 8'h0F, {4'h0, o_join_pair_hi, o_join_pair_lo, o_pulse_output_sel});
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h10);
		rd("low pair only", pwmcs_pkg::ADDR_CONTROL, 8'h10);
		cmp("low joined", 8'h05, {4'h0, o_join_pair_hi, o_join_pair_lo, o_pulse_output_sel});
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h20);
		rd("high pair only", pwmcs_pkg::ADDR_CONTROL, 8'h20);
		cmp("high joined", 8'h0A, {4'h0, o_join_pair_hi, o_join_pair_lo, o_pulse_output_sel});
		// software only rejoins with channels off; nothing is enabled here
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h00);
		for (int i = 0; i < 4; i++) begin
			logic [7:0] a;
			a = (i == 0) ? pwmcs_pkg::ADDR_FACTORY_TEST : (i == 1) ? pwmcs_pkg::ADDR_FACTORY_PRESCALE :
				(i == 2) ? pwmcs_pkg::ADDR_SCALE_COUNT_A : pwmcs_pkg::ADDR_SCALE_COUNT_B;
			wr(a, 8'hA5);
			rd("reserved reads zero", a, 8'h00);
		end
		rd("unmapped", 8'h3F, 8'h00);
		wr(pwmcs_pkg::ADDR_PRESCALE, 8'hFF);
		rd("prescale mask", pwmcs_pkg::ADDR_PRESCALE, 8'h77);
		wr(pwmcs_pkg::ADDR_PRESCALE, 8'h00);
		wr(pwmcs_pkg::ADDR_SCALE_A, 8'h03);
		wr(pwmcs_pkg::ADDR_SCALE_B, 8'h05);
		rd("scale a readback", pwmcs_pkg::ADDR_SCALE_A, 8'h03);
		period("scaled a half period", 1'b0, 3);
		period("scaled b half period", 1'b1, 5);
		wr(pwmcs_pkg::ADDR_PRESCALE, 8'h01);
		wr(pwmcs_pkg::ADDR_SCALE_A, 8'h02);
		period("clock a over two", 1'b0, 4);
		wr(pwmcs_pkg::ADDR_PRESCALE, 8'h70);
		wr(pwmcs_pkg::ADDR_SCALE_B, 8'h01);
		period("clock b over 128", 1'b1, 128);
		wr(pwmcs_pkg::ADDR_PRESCALE, 8'h00);
		wr(pwmcs_pkg::ADDR_SCALE_A, 8'h00);
		period("scale zero is 256", 1'b0, 256);
		wr(pwmcs_pkg::ADDR_SCALE_A, 8'd200);
		gap(1'b0, n);
		repeat (10) @(posedge i_clk);
		wr(pwmcs_pkg::ADDR_SCALE_A, 8'h04);
		gap(1'b0, n);
		// a stale count of 200 would need far longer than this
		cmp_n("reload on write", 1, int'(n >= 3 && n <= 6));
		wr(8'h0D, 8'h11);
		cmp("counter reset split", 8'h02, {4'h0, o_counter_reset});
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h20);
		wr(8'h0F, 8'h11);
		cmp("counter reset joined", 8'h0C, {4'h0, o_counter_reset});
		wr(pwmcs_pkg::ADDR_CLOCK_SELECT, 8'h02);
		rd("clock select readback", pwmcs_pkg::ADDR_CLOCK_SELECT, 8'h02);
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h00);
		ticks(0, n);
		cmp_n("chan 0 on clock a", 12, n);
		ticks(1, n);
		cmp_n("chan 1 on scaled a", 3, n);
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h10);
		ticks(0, n);
		cmp_n("joined chan 0 follows 1", 3, n);
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h08);
		i_wait_mode <= 1'b1;
		run_chk(1'b0);
		held = o_scaled_clock_a;
		repeat (20) @(posedge i_clk);
		cmp("halted scaled clock", {7'h00, held}, {7'h00, o_scaled_clock_a});
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h00);
		run_chk(1'b1);
		i_wait_mode <= 1'b0;
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h04);
		i_freeze_mode <= 1'b1;
		run_chk(1'b0);
		rd("access while frozen", pwmcs_pkg::ADDR_CONTROL, 8'h04);
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h00);
		run_chk(1'b1);
		wr(pwmcs_pkg::ADDR_CONTROL, 8'h04);
		run_chk(1'b0);
		i_freeze_mode <= 1'b0;
		run_chk(1'b1);
		end_of_test();
	end
	initial begin
		repeat (20000) @(posedge i_clk);
		mismatches++;
		end_of_test();
	end
endmodule
